// file: rtl/tcss_chan_mem.sv
`timescale 1ns/10ps
module tcss_chan_mem
  import tcss_pkg::*;
#(
  parameter int WORDS = 32,
  parameter int W     = 28,
  parameter int AW    = 5
) (
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  input  wire logic          a_we_in,
  input  wire logic [AW-1:0] a_addr_in,
  input  wire logic [W-1:0]  a_mask_in,
  input  wire logic [W-1:0]  a_data_in,
  input  wire logic          b_we_in,
  input  wire logic [AW-1:0] b_addr_in,
  input  wire logic [W-1:0]  b_mask_in,
  input  wire logic [W-1:0]  b_data_in,
  input  wire logic [AW-1:0] r0_addr_in,
  output logic      [W-1:0]  r0_data_out,
  input  wire logic [AW-1:0] r1_addr_in,
  output logic      [W-1:0]  r1_data_out
);
  typedef struct packed {
    logic [WORDS-1:0][W-1:0] mem;
    logic [W-1:0]            r0;
    logic [W-1:0]            r1;
  } tcss_mem_state_type;

  tcss_mem_state_type st_q, st_d;

  // Port b first, port a last so hardware updates win a collision
  always_comb begin
    st_d = st_q;
    for (int i = 0; i < WORDS; i++) begin
      if (b_we_in && b_addr_in == AW'(i)) begin
        st_d.mem[i] = (st_d.mem[i] & ~b_mask_in) | (b_data_in & b_mask_in);
      end
      if (a_we_in && a_addr_in == AW'(i)) begin
        st_d.mem[i] = (st_d.mem[i] & ~a_mask_in) | (a_data_in & a_mask_in);
      end
    end
    st_d.r0 = st_q.mem[r0_addr_in];
    st_d.r1 = st_q.mem[r1_addr_in];
  end

  // Registered storage and read data
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign r0_data_out = st_q.r0;
  assign r1_data_out = st_q.r1;
endmodule // tcss_chan_mem

// file: rtl/tcss_fifo.sv
`timescale 1ns/10ps
module tcss_fifo #(
  parameter int W     = 20,
  parameter int DEPTH = 8,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  input  wire logic          in_valid_in,
  input  wire logic [W-1:0]  in_data_in,
  output logic               in_ready_out,
  output logic               out_valid_out,
  output logic      [W-1:0]  out_data_out,
  input  wire logic          out_ready_in,
  output logic      [CW-1:0] count_out
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] q;
    logic [CW-1:0]           cnt;
  } tcss_fifo_state_type;

  tcss_fifo_state_type st_q, st_d;
  logic                push;
  logic                pop;

  // Shift queue: entry 0 is always the head
  always_comb begin
    st_d = st_q;
    push = in_valid_in && (st_q.cnt != CW'(DEPTH));
    pop  = out_ready_in && (st_q.cnt != '0);
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        st_d.q[i] = st_q.q[i+1];
      end
    end
    if (push) begin
      st_d.q[st_q.cnt - CW'(pop)] = in_data_in;
    end
    st_d.cnt = st_q.cnt + CW'(push) - CW'(pop);
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign in_ready_out  = st_q.cnt != CW'(DEPTH);
  assign out_valid_out = st_q.cnt != '0;
  assign out_data_out  = st_q.q[0];
  assign count_out     = st_q.cnt;
endmodule // tcss_fifo

// file: rtl/tcss_pkg.sv
package tcss_pkg;
  // Channel table geometry
  localparam int          TCSS_SLOTS     = 32;
  localparam int          TCSS_SLOT_W    = 5;
  localparam int          TCSS_ADDR_W    = 9;
  // Register map, one byte per printed offset
  localparam logic [8:0]  TCSS_CTRL_BASE = 9'h100;
  localparam logic [8:0]  TCSS_SIG_BASE  = 9'h120;
  localparam logic [8:0]  TCSS_SLO_BASE  = 9'h140;
  localparam logic [8:0]  TCSS_CFG_ADDR  = 9'h0c0;
  localparam logic [8:0]  TCSS_STAT_ADDR = 9'h0c1;
  // Channel control field positions
  localparam int          TCSS_ZS_BIT    = 7;
  localparam int          TCSS_LOOP_BIT  = 6;
  localparam int          TCSS_IDLE_BIT  = 5;
  localparam int          TCSS_LOCAL_BIT = 4;
  localparam int          TCSS_TSEL_BIT  = 3;
  localparam int          TCSS_RSEL_BIT  = 2;
  // Bit 7 of the slot (first sent is bit 1) sits at byte position 1
  localparam int          TCSS_B7_POS    = 1;
  // Config register fields
  localparam int          TCSS_CFG_E1    = 0;
  localparam logic        TCSS_CFG_RST   = 1'b0;
  // E1 slots carrying multiframe alignment and extra bits
  localparam logic [4:0]  TCSS_E1_TS0    = 5'h00;
  localparam logic [4:0]  TCSS_E1_TS16   = 5'h10;
  // Packed memory word: slip high, slip low, signaling, control
  localparam int          TCSS_MW_CTRL   = 0;
  localparam int          TCSS_MW_SIG    = 8;
  localparam int          TCSS_MW_SLO    = 12;
  localparam int          TCSS_MW_SHI    = 20;
  localparam int          TCSS_MEM_W     = 28;
  localparam logic [27:0] TCSS_MEM_RST   = 28'h0000000;
  // Output queue
  localparam int          TCSS_FIFO_D    = 8;
  localparam int          TCSS_OUT_W     = 20;
  // Register region codes
  typedef enum logic [1:0] {
    TCSS_REG_NONE = 2'b00,
    TCSS_REG_CTRL = 2'b01,
    TCSS_REG_SIG  = 2'b11,
    TCSS_REG_SLO  = 2'b10
  } tcss_region_type;
endpackage

// file: rtl/tcss_top.sv
// What this block does
// - Separate control entry for each of 32 slots
// - T1 assigned zero byte forces bit 7 high
// - T1 unassigned idle slot forces embedded F-bit
// - Loop and idle bits pick the data source
// - Idle keeps updating slip high, never slip low
// - Local select sends local ABCD, ignores buffers
// - Transmit buffer select loops transmit signaling
// - Receive buffer select loops receive signaling
// - Receive signaling comes from its output half
// - E1 slots 0 and 16 send local values
// - Incoming signaling is stored per channel
// - Signaling entry uses bits 3..0, upper zero
// - E1 entries 0 and 16 hold alignment bits
// - Slip low bit 7 is first-sent bit
`timescale 1ns/10ps
module tcss_top
  import tcss_pkg::*;
#(
  parameter int FIFO_DEPTH = TCSS_FIFO_D
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Register port
  input  wire logic [8:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // Slot input from the system bus side
  input  wire logic       slot_valid_in,
  output logic            slot_ready_out,
  input  wire logic [4:0] slot_num_in,
  input  wire logic       slot_assigned_in,
  input  wire logic [7:0] tx_pcm_in,
  input  wire logic       tx_sig_valid_in,
  input  wire logic [3:0] tx_sig_in,
  input  wire logic [7:0] rx_slip_in,
  input  wire logic [3:0] rx_sig_buffer_in,
  // Built slot toward the framer
  output logic            out_valid_out,
  input  wire logic       out_ready_in,
  output logic      [4:0] out_slot_out,
  output logic      [7:0] out_data_out,
  output logic      [3:0] out_sig_out,
  output logic            out_sig_insert_out,
  output logic            out_fbit_force_out,
  output logic            out_fbit_value_out
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  // Read data select codes
  localparam logic [1:0] RD_HOLD = 2'b00;
  localparam logic [1:0] RD_CTRL = 2'b01;
  localparam logic [1:0] RD_SIG  = 2'b10;
  localparam logic [1:0] RD_SLO  = 2'b11;

  typedef struct packed {
    logic       s1_valid;
    logic [4:0] s1_slot;
    logic       s1_assigned;
    logic [7:0] s1_pcm;
    logic [7:0] s1_rx_data;
    logic [3:0] s1_rx_sig;
    logic       slot_ready;
    logic       e1_mode;
    logic [1:0] rd_sel;
    logic [7:0] rd_hold;
  } tcss_state_type;

  tcss_state_type        st_q, st_d;

  // Memory and queue wiring
  logic                  accept;
  logic                  a_we;
  logic [TCSS_MEM_W-1:0] a_mask;
  logic [TCSS_MEM_W-1:0] a_data;
  logic                  b_we;
  logic [TCSS_MEM_W-1:0] b_mask;
  logic [TCSS_MEM_W-1:0] b_data;
  logic [TCSS_MEM_W-1:0] r0_word;
  logic [TCSS_MEM_W-1:0] r1_word;
  tcss_region_type       wr_region;
  tcss_region_type       rd_region;

  // Slot build results
  logic [7:0]            ctrl;
  logic [3:0]            sig_buf;
  logic [7:0]            slip_lo;
  logic [7:0]            data;
  logic [3:0]            sig;
  logic                  sig_ins;
  logic                  fbit_force;
  logic                  e1_aux_slot;
  logic [TCSS_OUT_W-1:0] push_word;
  logic [TCSS_OUT_W-1:0] head_word;
  logic [CW-1:0]         fifo_cnt;

  // Map an address onto one of the per-channel tables
  function automatic tcss_region_type tcss_region(input logic [8:0] addr);
    unique case (addr[8:5])
      TCSS_CTRL_BASE[8:5]: tcss_region = TCSS_REG_CTRL;
      TCSS_SIG_BASE[8:5]:  tcss_region = TCSS_REG_SIG;
      TCSS_SLO_BASE[8:5]:  tcss_region = TCSS_REG_SLO;
      default:             tcss_region = TCSS_REG_NONE;
    endcase
  endfunction

  // Per-channel tables, one word per slot
  tcss_chan_mem #(
    .WORDS (TCSS_SLOTS),
    .W     (TCSS_MEM_W),
    .AW    (TCSS_SLOT_W)
  ) u_mem (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .a_we_in     (a_we),
    .a_addr_in   (slot_num_in),
    .a_mask_in   (a_mask),
    .a_data_in   (a_data),
    .b_we_in     (b_we),
    .b_addr_in   (reg_addr_in[4:0]),
    .b_mask_in   (b_mask),
    .b_data_in   (b_data),
    .r0_addr_in  (slot_num_in),
    .r0_data_out (r0_word),
    .r1_addr_in  (reg_addr_in[4:0]),
    .r1_data_out (r1_word)
  );

  // Output queue between slot build and framer
  tcss_fifo #(
    .W     (TCSS_OUT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (st_q.s1_valid),
    .in_data_in    (push_word),
    .in_ready_out  (),
    .out_valid_out (out_valid_out),
    .out_data_out  (head_word),
    .out_ready_in  (out_ready_in),
    .count_out     (fifo_cnt)
  );

  // Slot fetch side writes: slip high always, signaling when offered
  always_comb begin
    accept = slot_valid_in && st_q.slot_ready;
    a_we   = accept;
    a_mask = '0;
    a_mask[TCSS_MW_SHI +: 8] = 8'hff;
    if (tx_sig_valid_in) begin
      a_mask[TCSS_MW_SIG +: 4] = 4'hf;
    end
    a_data = '0;
    a_data[TCSS_MW_SHI +: 8] = tx_pcm_in;
    a_data[TCSS_MW_SIG +: 4] = tx_sig_in;
  end

  // Host writes into the tables
  always_comb begin
    wr_region = tcss_region(reg_addr_in);
    b_we      = reg_wr_in && (wr_region != TCSS_REG_NONE);
    b_mask    = '0;
    unique case (wr_region)
      TCSS_REG_CTRL: b_mask[TCSS_MW_CTRL +: 8] = 8'hff;
      TCSS_REG_SIG:  b_mask[TCSS_MW_SIG +: 4]  = 4'hf;
      TCSS_REG_SLO:  b_mask[TCSS_MW_SLO +: 8]  = 8'hff;
      TCSS_REG_NONE: b_mask = '0;
    endcase
    b_data = '0;
    b_data[TCSS_MW_CTRL +: 8] = reg_wdata_in;
    b_data[TCSS_MW_SIG +: 4]  = reg_wdata_in[3:0];
    b_data[TCSS_MW_SLO +: 8]  = reg_wdata_in;
  end

  // Build one slot from the control read at the slot's start
  always_comb begin
    ctrl    = r0_word[TCSS_MW_CTRL +: 8];
    sig_buf = r0_word[TCSS_MW_SIG +: 4];
    slip_lo = r0_word[TCSS_MW_SLO +: 8];
    // Data source
    if (ctrl[TCSS_IDLE_BIT]) begin
      data = slip_lo;
    end else if (ctrl[TCSS_LOOP_BIT]) begin
      data = st_q.s1_rx_data;
    end else begin
      data = st_q.s1_pcm;
    end
    // Bit 7 zero code substitution
    if (!st_q.e1_mode && st_q.s1_assigned && ctrl[TCSS_ZS_BIT]
        && data == 8'h00) begin
      data[TCSS_B7_POS] = 1'b1;
    end
    // Forced embedded F-bit
    fbit_force = !st_q.e1_mode && !st_q.s1_assigned
                 && ctrl[TCSS_IDLE_BIT];
    // Signaling source
    e1_aux_slot = st_q.e1_mode && (st_q.s1_slot == TCSS_E1_TS0
                                   || st_q.s1_slot == TCSS_E1_TS16);
    sig     = 4'h0;
    sig_ins = 1'b1;
    if (e1_aux_slot) begin
      sig = ctrl[3:0];
    end else if (ctrl[TCSS_LOCAL_BIT]) begin
      sig = ctrl[3:0];
    end else if (ctrl[TCSS_TSEL_BIT]) begin
      sig = sig_buf;
    end else if (ctrl[TCSS_RSEL_BIT]) begin
      sig = st_q.s1_rx_sig;
    end else begin
      sig_ins = 1'b0;
    end
    push_word = {st_q.s1_slot, data, sig, sig_ins, fbit_force,
                 ctrl[TCSS_ZS_BIT]};
  end

  // Pipeline, ready, config and read path next state
  always_comb begin
    st_d             = st_q;
    rd_region        = tcss_region(reg_addr_in);
    st_d.s1_valid    = accept;
    if (accept) begin
      st_d.s1_slot     = slot_num_in;
      st_d.s1_assigned = slot_assigned_in;
      st_d.s1_pcm      = tx_pcm_in;
      st_d.s1_rx_data  = rx_slip_in;
      st_d.s1_rx_sig   = rx_sig_buffer_in;
    end
    // Leave room for the slot in flight and the ready lag
    st_d.slot_ready = fifo_cnt < CW'(FIFO_DEPTH - 2);
    // Config write
    if (reg_wr_in && reg_addr_in == TCSS_CFG_ADDR) begin
      st_d.e1_mode = reg_wdata_in[TCSS_CFG_E1];
    end
    // Read select, answered in the next cycle
    if (reg_rd_in) begin
      st_d.rd_hold = 8'h00;
      unique case (rd_region)
        TCSS_REG_CTRL: st_d.rd_sel = RD_CTRL;
        TCSS_REG_SIG:  st_d.rd_sel = RD_SIG;
        TCSS_REG_SLO:  st_d.rd_sel = RD_SLO;
        TCSS_REG_NONE: st_d.rd_sel = RD_HOLD;
      endcase
      if (reg_addr_in == TCSS_CFG_ADDR) begin
        st_d.rd_hold[TCSS_CFG_E1] = st_q.e1_mode;
      end else if (reg_addr_in == TCSS_STAT_ADDR) begin
        st_d.rd_hold = {3'h0, st_q.slot_ready, 4'(fifo_cnt)};
      end
    end else begin
      st_d.rd_sel  = RD_HOLD;
      st_d.rd_hold = 8'h00;
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q         <= '0;
      st_q.e1_mode <= TCSS_CFG_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Read data, zero outside the answer cycle
  always_comb begin
    unique case (st_q.rd_sel)
      RD_CTRL: reg_rdata_out = r1_word[TCSS_MW_CTRL +: 8];
      RD_SIG:  reg_rdata_out = {4'h0, r1_word[TCSS_MW_SIG +: 4]};
      RD_SLO:  reg_rdata_out = r1_word[TCSS_MW_SLO +: 8];
      RD_HOLD: reg_rdata_out = st_q.rd_hold;
    endcase
  end

  // Output fields come from the queue head register
  assign slot_ready_out     = st_q.slot_ready;
  assign out_slot_out       = head_word[19:15];
  assign out_data_out       = head_word[14:7];
  assign out_sig_out        = head_word[6:3];
  assign out_sig_insert_out = head_word[2];
  assign out_fbit_force_out = head_word[1];
  assign out_fbit_value_out = head_word[0];
endmodule // tcss_top

// file: verification/tcss_sink_model.sv
`timescale 1ns/10ps
// Framer side: takes each built slot unless stalled
module tcss_sink_model (
  input  wire logic        clk_in,
  input  wire logic        stall_in,
  input  wire logic        valid_in,
  input  wire logic [19:0] word_in,
  output logic             ready_out,
  output logic      [19:0] got_out,
  output int               pops_out
);
  initial begin
    ready_out = 1'b0;
    got_out   = 20'h00000;
    pops_out  = 0;
  end
  // Capture the head on each accepted transfer
  always @(posedge clk_in) begin
    if (valid_in && ready_out) begin
      got_out  <= word_in;
      pops_out <= pops_out + 1;
    end
    ready_out <= !stall_in;
  end
endmodule // tcss_sink_model

// file: verification/tcss_top_sva.sv
`timescale 1ns/10ps
module tcss_top_sva
  import tcss_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic [8:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       slot_valid_in,
  input wire logic       slot_ready_out,
  input wire logic [4:0] slot_num_in,
  input wire logic       out_valid_out,
  input wire logic       out_ready_in,
  input wire logic [4:0] out_slot_out,
  input wire logic [3:0] out_sig_out,
  input wire logic       out_sig_insert_out,
  input wire logic       out_fbit_force_out
);
  logic e1_q;
  // Shadow of the line mode bit
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      e1_q <= 1'b0;
    end else if (reg_wr_in && reg_addr_in == TCSS_CFG_ADDR) begin
      e1_q <= reg_wdata_in[TCSS_CFG_E1];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Slot handed over, and a control write read back at once
  sequence s_take;
    slot_valid_in && slot_ready_out;
  endsequence
  sequence s_wr_rd;
    reg_wr_in && reg_addr_in[8:5] == 4'h8 ##1 reg_rd_in && $stable(reg_addr_in);
  endsequence
  a_rd_quiet: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside read cycle");
  a_ctrl_back: assert property (s_wr_rd |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("control entry read back wrong");
  a_sig_upper: assert property ($past(reg_rd_in) && $past(reg_addr_in[8:5]) == 4'h9
    |-> reg_rdata_out[7:4] == 4'h0) else $error("signaling upper bits not zero");
  a_no_sig: assert property (out_valid_out && !out_sig_insert_out |-> out_sig_out == 4'h0)
    else $error("signaling present without insert");
  a_e1_align: assert property (out_valid_out && e1_q && out_slot_out[3:0] == 4'h0
    |-> out_sig_insert_out) else $error("E1 slot 0 or 16 lacks local signaling");
  a_fbit_t1: assert property (out_valid_out && out_fbit_force_out |-> !e1_q)
    else $error("F-bit forced in E1");
  a_ready_up: assert property ($fell(rst_in) |=> slot_ready_out)
    else $error("slot ready late after reset");
  a_take_out: assert property (s_take ##0 (!out_valid_out &&
    !$past(slot_valid_in && slot_ready_out)) |-> ##2 out_valid_out &&
    out_slot_out == $past(slot_num_in, 2)) else $error("built slot missing or wrong");
  a_head_hold: assert property (out_valid_out && !out_ready_in |=> out_valid_out &&
    $stable(out_slot_out) && $stable(out_sig_out)) else $error("queue head moved");
endmodule // tcss_top_sva

// file: verification/tcss_top_test.sv
`timescale 1ns/10ps
module tcss_top_test;
  import tcss_pkg::*;
  logic clk_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic slot_valid_in = 1'b0, slot_assigned_in = 1'b0, tx_sig_valid_in = 1'b0;
  logic stall = 1'b0, slot_ready_out, out_valid_out, out_ready_in;
  logic out_sig_insert_out, out_fbit_force_out, out_fbit_value_out;
  logic [8:0] reg_addr_in = 9'h000;
  logic [7:0] reg_wdata_in = 8'h00, tx_pcm_in = 8'h00, reg_rdata_out, out_data_out;
  logic [7:0] rx_slip_in = 8'hc3;
  logic [4:0] slot_num_in = 5'h00, out_slot_out;
  logic [3:0] tx_sig_in = 4'h0, rx_sig_buffer_in = 4'h6, out_sig_out;
  logic [19:0] got;
  int pops, cycles = 0, mismatches = 0, cmp_count = 0;
  localparam int FIFO_DEPTH_TB = TCSS_FIFO_D;
  tcss_top uut (.clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .slot_valid_in, .slot_ready_out, .slot_num_in,
    .slot_assigned_in, .tx_pcm_in, .tx_sig_valid_in, .tx_sig_in, .rx_slip_in,
    .rx_sig_buffer_in, .out_valid_out, .out_ready_in, .out_slot_out, .out_data_out,
    .out_sig_out, .out_sig_insert_out, .out_fbit_force_out, .out_fbit_value_out);
  tcss_sink_model sink (.clk_in, .stall_in(stall), .valid_in(out_valid_out),
    .word_in({out_slot_out, out_data_out, out_sig_out, out_sig_insert_out,
    out_fbit_force_out, out_fbit_value_out}), .ready_out(out_ready_in),
    .got_out(got), .pops_out(pops));
  always #5 clk_in = ~clk_in;
  // Cut a hang short
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [19:0] g, e, m);
    cmp_count++;
    if ((g | m) !== (e | m)) begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Register writes leave the strobe up for the next task to drop
  task automatic wr(input logic [8:0] b, input logic [4:0] i, input logic [7:0] d);
    @(posedge clk_in);
    reg_rd_in    <= 1'b0;
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= b + {4'h0, i};
    reg_wdata_in <= d;
  endtask
  task automatic rd(input logic [8:0] b, input logic [4:0] i, input logic [7:0] e);
    @(posedge clk_in);
    reg_wr_in   <= 1'b0;
    reg_rd_in   <= 1'b1;
    reg_addr_in <= b + {4'h0, i};
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    chk({12'h000, reg_rdata_out}, {12'h000, e}, 20'h00000);
  endtask
  // Offer one slot, s[4] stores s[3:0] as its signaling
  task automatic push(input logic [4:0] n, input logic a, input logic [7:0] p,
                      input logic [4:0] s);
    @(posedge clk_in);
    reg_wr_in        <= 1'b0;
    slot_valid_in    <= 1'b1;
    slot_num_in      <= n;
    slot_assigned_in <= a;
    tx_pcm_in        <= p;
    tx_sig_valid_in  <= s[4];
    tx_sig_in        <= s[3:0];
    do @(negedge clk_in); while (!slot_ready_out);
    @(posedge clk_in);
    slot_valid_in   <= 1'b0;
    tx_sig_valid_in <= 1'b0;
  endtask
  // e holds data, signaling, insert, F-bit force and value
  task automatic slot(input logic [4:0] n, input logic a, input logic [7:0] p,
                      input logic [4:0] s, input logic [14:0] e);
    int k;
    k = pops;
    push(n, a, p, s);
    for (int i = 0; i < 20 && pops == k; i++) @(negedge clk_in);
    chk(got, {n, e}, {19'h00000, !e[1]});
  endtask
  task automatic t_regs();
    wr(TCSS_CTRL_BASE, 5'h05, 8'ha5);
    rd(TCSS_CTRL_BASE, 5'h05, 8'ha5);
    rd(TCSS_CTRL_BASE, 5'h06, 8'h00);
    wr(TCSS_SIG_BASE, 5'h03, 8'hff);
    rd(TCSS_SIG_BASE, 5'h03, 8'h0f);
    rd(9'h160, 5'h00, 8'h00);
    wr(TCSS_CTRL_BASE, 5'h05, 8'h00);
  endtask
  task automatic t_data();
    wr(TCSS_SLO_BASE, 5'h02, 8'h81);
    for (int i = 0; i < 4; i++) begin
      wr(TCSS_CTRL_BASE, 5'h02, {1'b0, 2'(i), 5'h00});
      slot(5'h02, 1'b1, 8'h5a, 5'h00, {i[0] ? 8'h81 : i[1] ? 8'hc3 : 8'h5a, 7'h00});
    end
    rd(TCSS_SLO_BASE, 5'h02, 8'h81);
  endtask
  task automatic t_zero();
    wr(TCSS_CTRL_BASE, 5'h04, 8'h80);
    slot(5'h04, 1'b1, 8'h00, 5'h00, {8'h02, 7'h00});
    slot(5'h04, 1'b1, 8'h01, 5'h00, {8'h01, 7'h00});
    wr(TCSS_CTRL_BASE, 5'h09, 8'ha0);
    wr(TCSS_SLO_BASE, 5'h09, 8'h7e);
    slot(5'h09, 1'b0, 8'h00, 5'h00, {8'h7e, 4'h0, 3'b011});
    wr(TCSS_CTRL_BASE, 5'h09, 8'h20);
    slot(5'h09, 1'b0, 8'h00, 5'h00, {8'h7e, 4'h0, 3'b010});
  endtask
  task automatic t_sig();
    wr(TCSS_CTRL_BASE, 5'h07, 8'h1a);
    slot(5'h07, 1'b1, 8'h11, 5'h00, {8'h11, 4'ha, 3'b100});
    wr(TCSS_CTRL_BASE, 5'h07, 8'h1c);
    slot(5'h07, 1'b1, 8'h11, 5'h00, {8'h11, 4'hc, 3'b100});
    wr(TCSS_CTRL_BASE, 5'h07, 8'h00);
    slot(5'h07, 1'b1, 8'h11, 5'h15, {8'h11, 4'h0, 3'b000});
    rd(TCSS_SIG_BASE, 5'h07, 8'h05);
    wr(TCSS_CTRL_BASE, 5'h07, 8'h08);
    slot(5'h07, 1'b1, 8'h11, 5'h00, {8'h11, 4'h5, 3'b100});
    wr(TCSS_CTRL_BASE, 5'h07, 8'h04);
    slot(5'h07, 1'b1, 8'h11, 5'h00, {8'h11, 4'h6, 3'b100});
  endtask
  task automatic t_e1();
    wr(TCSS_CFG_ADDR, 5'h00, 8'h01);
    wr(TCSS_CTRL_BASE, 5'h00, 8'h0b);
    wr(TCSS_CTRL_BASE, 5'h10, 8'h06);
    wr(TCSS_CTRL_BASE, 5'h01, 8'h80);
    slot(5'h00, 1'b1, 8'h22, 5'h00, {8'h22, 4'hb, 3'b100});
    slot(5'h10, 1'b1, 8'h33, 5'h19, {8'h33, 4'h6, 3'b100});
    rd(TCSS_SIG_BASE, 5'h10, 8'h09);
    slot(5'h01, 1'b1, 8'h00, 5'h00, {8'h00, 7'h00});
    wr(TCSS_CFG_ADDR, 5'h00, 8'h00);
  endtask
  task automatic t_fifo();
    int n, k;
    n = 0;
    k = pops;
    @(posedge clk_in);
    reg_wr_in     <= 1'b0;
    stall         <= 1'b1;
    slot_valid_in <= 1'b1;
    repeat (16) begin
      @(negedge clk_in);
      n += int'(slot_ready_out);
    end
    @(posedge clk_in);
    slot_valid_in <= 1'b0;
    stall         <= 1'b0;
    @(negedge clk_in);
    chk({19'h00000, slot_ready_out}, 20'h00000, 20'h00000);
    chk({19'h00000, n > 0 && n <= FIFO_DEPTH_TB}, 20'h00001, 20'h00000);
    for (int i = 0; i < 40 && pops != k + n; i++) @(negedge clk_in);
    chk({19'h00000, out_valid_out}, 20'h00000, 20'h00000);
    chk(pops - k, n, 20'h00000);
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    t_regs();
    t_data();
    t_zero();
    t_sig();
    t_e1();
    t_fifo();
    conclude();
  end
endmodule // tcss_top_test
bind tcss_top tcss_top_sva u_sva (.clk_in, .rst_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .slot_valid_in, .slot_ready_out,
  .slot_num_in, .out_valid_out, .out_ready_in, .out_slot_out, .out_sig_out,
  .out_sig_insert_out, .out_fbit_force_out);
